// file: gefg_board.sv
// board model: pads driven by the device, the board or a pull-up
`timescale 1ns/1ps
module gefg_board #(
  parameter int N = 9
) (
  input wire logic clk,
  input wire logic [N-1:0] oe,
  input wire logic [N-1:0] out,
  input wire logic [N-1:0] pull,
  input wire logic [N-1:0] drv,
  input wire logic [N-1:0] drv_en,
  output logic [N-1:0] lvl
);
  logic [N-1:0] flip = '0;
  // a floating pad without pull-up wanders every cycle
  always @(posedge clk) flip <= ~flip;
  // device drive wins, then the board, then the pull-up
  assign lvl = (oe & out) | (~oe & drv_en & drv) | (~oe & ~drv_en & (pull | flip));
endmodule

// file: gefg_pkg.sv
// shared constants, modes and peripheral carriers for the e/f/g pin groups
package gefg_pkg;

  // register byte addresses on the apb bus
  localparam logic [31:0] E_CONFIG_ADDR = 32'h01D20028;
  localparam logic [31:0] E_DATA_ADDR = 32'h01D2002C;
  localparam logic [31:0] E_PULLUP_ADDR = 32'h01D20030;
  localparam logic [31:0] F_CONFIG_ADDR = 32'h01D20034;
  localparam logic [31:0] F_DATA_ADDR = 32'h01D20038;
  localparam logic [31:0] F_PULLUP_ADDR = 32'h01D2003C;
  localparam logic [31:0] G_CONFIG_ADDR = 32'h01D20040;
  localparam logic [31:0] G_DATA_ADDR = 32'h01D20044;
  localparam logic [31:0] G_PULLUP_ADDR = 32'h01D20048;

  // pin counts and register widths
  localparam int E_PINS = 9;
  localparam int F_PINS = 9;
  localparam int G_PINS = 8;
  localparam int E_PULL_PINS = 8;
  localparam int E_CONFIG_W = 18;
  localparam int F_CONFIG_W = 22;
  localparam int G_CONFIG_W = 16;

  // field layout of the group f configuration word
  localparam int F_WIDE_FIRST_PIN = 5;
  localparam int F_WIDE_BASE = 10;

  // values after reset
  localparam logic [E_CONFIG_W-1:0] E_CONFIG_RESET = 18'h00000;
  localparam logic [F_CONFIG_W-1:0] F_CONFIG_RESET = 22'h000000;
  localparam logic [G_CONFIG_W-1:0] G_CONFIG_RESET = 16'h0000;
  localparam logic [E_PULL_PINS-1:0] E_PULLUP_RESET = 8'h00;
  localparam logic [F_PINS-1:0] F_PULLUP_RESET = 9'h000;
  localparam logic [G_PINS-1:0] G_PULLUP_RESET = 8'h00;
  localparam logic [E_PINS-1:0] E_DATA_RESET = 9'h000;
  localparam logic [F_PINS-1:0] F_DATA_RESET = 9'h000;
  localparam logic [G_PINS-1:0] G_DATA_RESET = 8'h00;

  // two-bit pin mode codes
  typedef enum logic [1:0] {
    MODE2_INPUT = 2'b00,
    MODE2_OUTPUT = 2'b01,
    MODE2_FUNC_A = 2'b10,
    MODE2_FUNC_B = 2'b11
  } gefg_mode2_e;

  // three-bit pin mode codes of group f pins 8..5
  typedef enum logic [2:0] {
    MODE3_INPUT = 3'b000,
    MODE3_OUTPUT = 3'b001,
    MODE3_UART1 = 3'b010,
    MODE3_SYNC_SERIAL = 3'b011,
    MODE3_AUDIO = 3'b100
  } gefg_mode3_e;

  // signals the peripherals offer for driving onto pins
  typedef struct packed {
    logic codec_clock_out;
    logic display_data_bit7;
    logic display_data_bit6;
    logic display_data_bit5;
    logic display_data_bit4;
    logic clock_out;
    logic uart1_transmit;
    logic uart1_request_to_send_n;
    logic uart0_request_to_send_n;
    logic sync_serial_clock;
    logic sync_serial_clock_oe;
    logic sync_serial_transmit;
    logic sync_serial_ready;
    logic audio_bit_clock;
    logic audio_bit_clock_oe;
    logic audio_word_select;
    logic audio_word_select_oe;
    logic audio_data_out;
    logic ext_bus_grant_n;
    logic dma0_acknowledge_n;
    logic two_wire_data_low;
    logic two_wire_clock_low;
  } gefg_periph_drive_s;

  // pin levels routed to the peripherals, idle when not selected
  typedef struct packed {
    logic timer_ext_clock_in;
    logic uart0_receive;
    logic uart0_clear_to_send_n;
    logic uart1_receive;
    logic uart1_clear_to_send_n;
    logic sync_serial_clock_in;
    logic sync_serial_receive;
    logic audio_bit_clock_in;
    logic audio_word_select_in;
    logic audio_data_in;
    logic ext_bus_request_n;
    logic bus_wait_n;
    logic two_wire_data;
    logic two_wire_clock;
    logic [7:0] ext_interrupt_in;
  } gefg_periph_sense_s;

endpackage

// file: gefg_top.sv
// pin configuration, data and pull-up logic of the e, f and g pin groups
// Operation
// - e8 codes 01 output, 10 codec clock; strap
// - e2 code 10 feeds uart0 receive
// - code 11: e5/e4 timer clock, e7/e6 display
// - e0 code 11 drives clock out
// - group e pull-ups cover pins 7..0 only
// - pull-up bit 0 enables, 1 disables
// - input pins read back pin level
// - output pins driven from data bit
// - function pins read back unspecified value
// - f8..f5 three-bit modes: in/out/uart1/serial/audio
// - f8 serial/audio clocks, f5 transmit/word select
// - f4..f0 code 10 bus/two-wire, f3 11 dma
// - group f registers decoded, config resets zero
// - group f pull-up register resets zero
// - g pins: in, out, function, ext interrupt
// - group g registers decoded, config/pull-up reset zero
// - group e registers decoded, config/pull-up reset zero
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

module gefg_top #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [gefg_pkg::E_PINS-1:0] pin_in_e,
  output logic [gefg_pkg::E_PINS-1:0] pin_out_e,
  output logic [gefg_pkg::E_PINS-1:0] pin_oe_e,
  output logic [gefg_pkg::E_PULL_PINS-1:0] pullup_en_e,
  input wire logic [gefg_pkg::F_PINS-1:0] pin_in_f,
  output logic [gefg_pkg::F_PINS-1:0] pin_out_f,
  output logic [gefg_pkg::F_PINS-1:0] pin_oe_f,
  output logic [gefg_pkg::F_PINS-1:0] pullup_en_f,
  input wire logic [gefg_pkg::G_PINS-1:0] pin_in_g,
  output logic [gefg_pkg::G_PINS-1:0] pin_out_g,
  output logic [gefg_pkg::G_PINS-1:0] pin_oe_g,
  output logic [gefg_pkg::G_PINS-1:0] pullup_en_g,
  input wire gefg_pkg::gefg_periph_drive_s periph_drive,
  output gefg_pkg::gefg_periph_sense_s periph_sense,
  output logic byte_order_select
);

  // the decode compares against addresses that need 25 bits
  if (ADDR_W < 25 || ADDR_W > 32)
  begin : g_addr_check
    $error("gefg_top: ADDR_W must lie between 25 and 32");
  end

  // mode of a pin with a two-bit field at position 2*idx
  function automatic gefg_pkg::gefg_mode2_e mode2(input logic [21:0] cfg, input int idx);
    mode2 = gefg_pkg::gefg_mode2_e'(cfg[2*idx +: 2]);
  endfunction

  // mode of group f pins 8..5 with three-bit fields
  function automatic logic [2:0] mode3(input logic [21:0] cfg, input int idx);
    mode3 = cfg[gefg_pkg::F_WIDE_BASE + 3*(idx - gefg_pkg::F_WIDE_FIRST_PIN) +: 3];
  endfunction

  // address match of the incoming bus address
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [31:0] target);
    hit = (addr == target[ADDR_W-1:0]);
  endfunction

  logic [gefg_pkg::E_CONFIG_W-1:0] group_e_pin_config;
  logic [gefg_pkg::E_PINS-1:0] group_e_pin_data;
  logic [gefg_pkg::E_PULL_PINS-1:0] group_e_pullup_disable;
  logic [gefg_pkg::F_CONFIG_W-1:0] group_f_pin_config;
  logic [gefg_pkg::F_PINS-1:0] group_f_pin_data;
  logic [gefg_pkg::F_PINS-1:0] group_f_pullup_disable;
  logic [gefg_pkg::G_CONFIG_W-1:0] group_g_pin_config;
  logic [gefg_pkg::G_PINS-1:0] group_g_pin_data;
  logic [gefg_pkg::G_PINS-1:0] group_g_pullup_disable;
  logic [21:0] cfg_e;
  logic [21:0] cfg_f;
  logic [21:0] cfg_g;
  logic [gefg_pkg::E_PINS-1:0] is_output_e;
  logic [gefg_pkg::F_PINS-1:0] is_output_f;
  logic [gefg_pkg::G_PINS-1:0] is_output_g;
  logic [2:0] mode_f8;
  logic [2:0] mode_f7;
  logic [2:0] mode_f6;
  logic [2:0] mode_f5;
  logic bus_write;
  logic bus_setup;
  logic addr_mapped;
  logic [31:0] next_prdata;

  // zero-extended configuration words for the field functions
  assign cfg_e = {4'h0, group_e_pin_config};
  assign cfg_f = group_f_pin_config;
  assign cfg_g = {6'h00, group_g_pin_config};
  assign mode_f8 = mode3(cfg_f, 8);
  assign mode_f7 = mode3(cfg_f, 7);
  assign mode_f6 = mode3(cfg_f, 6);
  assign mode_f5 = mode3(cfg_f, 5);

  // per-pin output mode flags; every other mode reads back the pin
  always_comb
  begin
    for (int i = 0; i < gefg_pkg::E_PINS; i++)
      is_output_e[i] = (mode2(cfg_e, i) == gefg_pkg::MODE2_OUTPUT);
    for (int i = 0; i < gefg_pkg::F_PINS; i++)
      if (i >= gefg_pkg::F_WIDE_FIRST_PIN)
        is_output_f[i] = (mode3(cfg_f, i) == gefg_pkg::MODE3_OUTPUT);
      else
        is_output_f[i] = (mode2(cfg_f, i) == gefg_pkg::MODE2_OUTPUT);
    for (int i = 0; i < gefg_pkg::G_PINS; i++)
      is_output_g[i] = (mode2(cfg_g, i) == gefg_pkg::MODE2_OUTPUT);
  end

  // apb decode, zero wait states
  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite;
  assign pready = psel && penable;
  assign addr_mapped = hit(paddr, gefg_pkg::E_CONFIG_ADDR) || hit(paddr, gefg_pkg::E_DATA_ADDR)
    || hit(paddr, gefg_pkg::E_PULLUP_ADDR) || hit(paddr, gefg_pkg::F_CONFIG_ADDR)
    || hit(paddr, gefg_pkg::F_DATA_ADDR) || hit(paddr, gefg_pkg::F_PULLUP_ADDR)
    || hit(paddr, gefg_pkg::G_CONFIG_ADDR) || hit(paddr, gefg_pkg::G_DATA_ADDR)
    || hit(paddr, gefg_pkg::G_PULLUP_ADDR);
  assign pslverr = psel && penable && !addr_mapped;

  // group e registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      group_e_pin_config <= gefg_pkg::E_CONFIG_RESET;
      group_e_pin_data <= gefg_pkg::E_DATA_RESET;
      group_e_pullup_disable <= gefg_pkg::E_PULLUP_RESET;
    end
    else if (bus_write)
    begin
      if (hit(paddr, gefg_pkg::E_CONFIG_ADDR))
        group_e_pin_config <= pwdata[gefg_pkg::E_CONFIG_W-1:0];
      if (hit(paddr, gefg_pkg::E_DATA_ADDR))
        group_e_pin_data <= pwdata[gefg_pkg::E_PINS-1:0];
      if (hit(paddr, gefg_pkg::E_PULLUP_ADDR))
        group_e_pullup_disable <= pwdata[gefg_pkg::E_PULL_PINS-1:0];
    end
  end

  // group f registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      group_f_pin_config <= gefg_pkg::F_CONFIG_RESET;
      group_f_pin_data <= gefg_pkg::F_DATA_RESET;
      group_f_pullup_disable <= gefg_pkg::F_PULLUP_RESET;
    end
    else if (bus_write)
    begin
      if (hit(paddr, gefg_pkg::F_CONFIG_ADDR))
        group_f_pin_config <= pwdata[gefg_pkg::F_CONFIG_W-1:0];
      if (hit(paddr, gefg_pkg::F_DATA_ADDR))
        group_f_pin_data <= pwdata[gefg_pkg::F_PINS-1:0];
      if (hit(paddr, gefg_pkg::F_PULLUP_ADDR))
        group_f_pullup_disable <= pwdata[gefg_pkg::F_PINS-1:0];
    end
  end

  // group g registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      group_g_pin_config <= gefg_pkg::G_CONFIG_RESET;
      group_g_pin_data <= gefg_pkg::G_DATA_RESET;
      group_g_pullup_disable <= gefg_pkg::G_PULLUP_RESET;
    end
    else if (bus_write)
    begin
      if (hit(paddr, gefg_pkg::G_CONFIG_ADDR))
        group_g_pin_config <= pwdata[gefg_pkg::G_CONFIG_W-1:0];
      if (hit(paddr, gefg_pkg::G_DATA_ADDR))
        group_g_pin_data <= pwdata[gefg_pkg::G_PINS-1:0];
      if (hit(paddr, gefg_pkg::G_PULLUP_ADDR))
        group_g_pullup_disable <= pwdata[gefg_pkg::G_PINS-1:0];
    end
  end

  // read mux: output pins return the data bit, all others the live pin
  always_comb
  begin
    next_prdata = 32'h00000000;
    if (hit(paddr, gefg_pkg::E_CONFIG_ADDR))
      next_prdata = {14'h0000, group_e_pin_config};
    if (hit(paddr, gefg_pkg::E_DATA_ADDR))
      next_prdata = {23'h000000, (is_output_e & group_e_pin_data) | (~is_output_e & pin_in_e)};
    if (hit(paddr, gefg_pkg::E_PULLUP_ADDR))
      next_prdata = {24'h000000, group_e_pullup_disable};
    if (hit(paddr, gefg_pkg::F_CONFIG_ADDR))
      next_prdata = {10'h000, group_f_pin_config};
    if (hit(paddr, gefg_pkg::F_DATA_ADDR))
      next_prdata = {23'h000000, (is_output_f & group_f_pin_data) | (~is_output_f & pin_in_f)};
    if (hit(paddr, gefg_pkg::F_PULLUP_ADDR))
      next_prdata = {23'h000000, group_f_pullup_disable};
    if (hit(paddr, gefg_pkg::G_CONFIG_ADDR))
      next_prdata = {16'h0000, group_g_pin_config};
    if (hit(paddr, gefg_pkg::G_DATA_ADDR))
      next_prdata = {24'h000000, (is_output_g & group_g_pin_data) | (~is_output_g & pin_in_g)};
    if (hit(paddr, gefg_pkg::G_PULLUP_ADDR))
      next_prdata = {24'h000000, group_g_pullup_disable};
  end

  // read data captured in the setup cycle, stable through the access
  always_ff @(posedge clk)
    if (!resetn)
      prdata <= 32'h00000000;
    else if (bus_setup && !pwrite)
      prdata <= next_prdata;

  // byte order strap held from the pin while reset is asserted
  always_ff @(posedge clk)
    if (!resetn)
      byte_order_select <= pin_in_e[8];

  // pull-up enables are the inverse of the disable bits
  assign pullup_en_e = ~group_e_pullup_disable;
  assign pullup_en_f = ~group_f_pullup_disable;
  assign pullup_en_g = ~group_g_pullup_disable;

  // group e pin drive
  always_comb
  begin
    pin_out_e = group_e_pin_data;
    pin_oe_e = is_output_e;
    if (mode2(cfg_e, 8) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_e[8] = periph_drive.codec_clock_out;
      pin_oe_e[8] = 1'b1;
    end
    if (mode2(cfg_e, 7) == gefg_pkg::MODE2_FUNC_B)
    begin
      pin_out_e[7] = periph_drive.display_data_bit7;
      pin_oe_e[7] = 1'b1;
    end
    if (mode2(cfg_e, 6) == gefg_pkg::MODE2_FUNC_B)
    begin
      pin_out_e[6] = periph_drive.display_data_bit6;
      pin_oe_e[6] = 1'b1;
    end
    if (mode2(cfg_e, 0) == gefg_pkg::MODE2_FUNC_B)
    begin
      pin_out_e[0] = periph_drive.clock_out;
      pin_oe_e[0] = 1'b1;
    end
  end

  // group f pin drive
  always_comb
  begin
    pin_out_f = group_f_pin_data;
    pin_oe_f = is_output_f;
    if (mode_f8 == gefg_pkg::MODE3_SYNC_SERIAL)
    begin
      pin_out_f[8] = periph_drive.sync_serial_clock;
      pin_oe_f[8] = periph_drive.sync_serial_clock_oe;
    end
    if (mode_f8 == gefg_pkg::MODE3_AUDIO)
    begin
      pin_out_f[8] = periph_drive.audio_bit_clock;
      pin_oe_f[8] = periph_drive.audio_bit_clock_oe;
    end
    unique case (mode_f6)
      gefg_pkg::MODE3_UART1:
      begin
        pin_out_f[6] = periph_drive.uart1_transmit;
        pin_oe_f[6] = 1'b1;
      end
      gefg_pkg::MODE3_SYNC_SERIAL:
      begin
        pin_out_f[6] = periph_drive.sync_serial_ready;
        pin_oe_f[6] = 1'b1;
      end
      gefg_pkg::MODE3_AUDIO:
      begin
        pin_out_f[6] = periph_drive.audio_data_out;
        pin_oe_f[6] = 1'b1;
      end
      default: ; // keeps the data-register drive set above
    endcase
    unique case (mode_f5)
      gefg_pkg::MODE3_UART1:
      begin
        pin_out_f[5] = periph_drive.uart1_request_to_send_n;
        pin_oe_f[5] = 1'b1;
      end
      gefg_pkg::MODE3_SYNC_SERIAL:
      begin
        pin_out_f[5] = periph_drive.sync_serial_transmit;
        pin_oe_f[5] = 1'b1;
      end
      gefg_pkg::MODE3_AUDIO:
      begin
        pin_out_f[5] = periph_drive.audio_word_select;
        pin_oe_f[5] = periph_drive.audio_word_select_oe;
      end
      default: ; // keeps the data-register drive set above
    endcase
    if (mode2(cfg_f, 3) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_f[3] = periph_drive.ext_bus_grant_n;
      pin_oe_f[3] = 1'b1;
    end
    if (mode2(cfg_f, 3) == gefg_pkg::MODE2_FUNC_B)
    begin
      pin_out_f[3] = periph_drive.dma0_acknowledge_n;
      pin_oe_f[3] = 1'b1;
    end
    // two-wire pins are open drain: only ever pulled low
    if (mode2(cfg_f, 1) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_f[1] = 1'b0;
      pin_oe_f[1] = periph_drive.two_wire_data_low;
    end
    if (mode2(cfg_f, 0) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_f[0] = 1'b0;
      pin_oe_f[0] = periph_drive.two_wire_clock_low;
    end
  end

  // group g pin drive; interrupt mode leaves the pin as an input
  always_comb
  begin
    pin_out_g = group_g_pin_data;
    pin_oe_g = is_output_g;
    if (mode2(cfg_g, 7) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_g[7] = periph_drive.audio_word_select;
      pin_oe_g[7] = periph_drive.audio_word_select_oe;
    end
    if (mode2(cfg_g, 6) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_g[6] = periph_drive.audio_data_out;
      pin_oe_g[6] = 1'b1;
    end
    if (mode2(cfg_g, 4) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_g[4] = periph_drive.audio_bit_clock;
      pin_oe_g[4] = periph_drive.audio_bit_clock_oe;
    end
    if (mode2(cfg_g, 3) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_g[3] = periph_drive.uart0_request_to_send_n;
      pin_oe_g[3] = 1'b1;
    end
    if (mode2(cfg_g, 1) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_g[1] = periph_drive.display_data_bit5;
      pin_oe_g[1] = 1'b1;
    end
    if (mode2(cfg_g, 0) == gefg_pkg::MODE2_FUNC_A)
    begin
      pin_out_g[0] = periph_drive.display_data_bit4;
      pin_oe_g[0] = 1'b1;
    end
  end

  // pin levels toward the peripherals; idle level when not selected
  always_comb
  begin
    periph_sense.timer_ext_clock_in = ((mode2(cfg_e, 5) == gefg_pkg::MODE2_FUNC_B) && pin_in_e[5])
      || ((mode2(cfg_e, 4) == gefg_pkg::MODE2_FUNC_B) && pin_in_e[4]);
    periph_sense.uart0_receive = (mode2(cfg_e, 2) == gefg_pkg::MODE2_FUNC_A) ? pin_in_e[2] : 1'b1;
    periph_sense.uart0_clear_to_send_n = (mode2(cfg_g, 2) == gefg_pkg::MODE2_FUNC_A) ? pin_in_g[2] : 1'b1;
    periph_sense.uart1_clear_to_send_n = (mode_f8 == gefg_pkg::MODE3_UART1) ? pin_in_f[8] : 1'b1;
    periph_sense.uart1_receive = (mode_f7 == gefg_pkg::MODE3_UART1) ? pin_in_f[7] : 1'b1;
    periph_sense.sync_serial_clock_in = (mode_f8 == gefg_pkg::MODE3_SYNC_SERIAL) && pin_in_f[8];
    periph_sense.sync_serial_receive = (mode_f7 == gefg_pkg::MODE3_SYNC_SERIAL) ? pin_in_f[7] : 1'b1;
    periph_sense.audio_bit_clock_in = ((mode_f8 == gefg_pkg::MODE3_AUDIO) && pin_in_f[8])
      || ((mode2(cfg_g, 4) == gefg_pkg::MODE2_FUNC_A) && pin_in_g[4]);
    periph_sense.audio_word_select_in = ((mode_f5 == gefg_pkg::MODE3_AUDIO) && pin_in_f[5])
      || ((mode2(cfg_g, 7) == gefg_pkg::MODE2_FUNC_A) && pin_in_g[7]);
    periph_sense.audio_data_in = ((mode_f7 == gefg_pkg::MODE3_AUDIO) && pin_in_f[7])
      || ((mode2(cfg_g, 5) == gefg_pkg::MODE2_FUNC_A) && pin_in_g[5]);
    periph_sense.ext_bus_request_n = (mode2(cfg_f, 4) == gefg_pkg::MODE2_FUNC_A) ? pin_in_f[4] : 1'b1;
    periph_sense.bus_wait_n = (mode2(cfg_f, 2) == gefg_pkg::MODE2_FUNC_A) ? pin_in_f[2] : 1'b1;
    periph_sense.two_wire_data = (mode2(cfg_f, 1) == gefg_pkg::MODE2_FUNC_A) ? pin_in_f[1] : 1'b1;
    periph_sense.two_wire_clock = (mode2(cfg_f, 0) == gefg_pkg::MODE2_FUNC_A) ? pin_in_f[0] : 1'b1;
    for (int i = 0; i < gefg_pkg::G_PINS; i++)
      periph_sense.ext_interrupt_in[i] = (mode2(cfg_g, i) == gefg_pkg::MODE2_FUNC_B) && pin_in_g[i];
  end

endmodule

// file: gefg_top_chk.sv
// assertion checker for the e/f/g pin logic
`timescale 1ns/1ps
module gefg_chk #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [gefg_pkg::E_PINS-1:0] pin_in_e,
  input wire logic [gefg_pkg::E_PINS-1:0] pin_out_e,
  input wire logic [gefg_pkg::E_PINS-1:0] pin_oe_e,
  input wire logic [gefg_pkg::E_PULL_PINS-1:0] pullup_en_e,
  input wire logic [gefg_pkg::F_PINS-1:0] pullup_en_f,
  input wire gefg_pkg::gefg_periph_drive_s periph_drive,
  input wire gefg_pkg::gefg_periph_sense_s periph_sense,
  input wire logic byte_order_select
);
  logic [17:0] e_cfg;
  wire acc = psel && penable;
  wire e_wr = acc && pwrite && paddr == gefg_pkg::E_CONFIG_ADDR;
  wire mapped = paddr >= gefg_pkg::E_CONFIG_ADDR && paddr <= gefg_pkg::G_PULLUP_ADDR && paddr[1:0] == 2'b00;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // shadow of the group e mode word
  always_ff @(posedge clk)
    if (!resetn)
      e_cfg <= '0;
    else if (e_wr)
      e_cfg <= pwdata[17:0];

  a_ready_zero_wait: assert property (acc |-> pready)
    else $error("no ready in access");
  a_unmapped_error: assert property (acc |-> pslverr == !mapped)
    else $error("wrong slave error");
  a_pullup_reset: assert property ($rose(resetn) |-> pullup_en_f == '1 && pullup_en_e == '1)
    else $error("pull-ups off after reset");
  a_e_pullup_write: assert property (acc && pwrite && paddr == gefg_pkg::E_PULLUP_ADDR
    |=> pullup_en_e == ~$past(pwdata[7:0]))
    else $error("pull-up enables wrong");
  a_strap_capture: assert property ($rose(resetn) |-> byte_order_select == $past(pin_in_e[8]))
    else $error("byte order not strapped");
  a_strap_hold: assert property ($past(resetn) |-> $stable(byte_order_select))
    else $error("byte order moved");
  a_uart_route: assert property (e_cfg[5:4] == 2'b10 |-> periph_sense.uart0_receive == pin_in_e[2])
    else $error("uart receive not routed");
  a_clock_out: assert property (e_cfg[1:0] == 2'b11
    |-> pin_oe_e[0] && pin_out_e[0] == periph_drive.clock_out)
    else $error("clock out not driven");
  a_e8_reserved: assert property (e_cfg[17:16] inside {2'b00, 2'b11} |-> !pin_oe_e[8])
    else $error("reserved pin driven");
  a_timer_clock: assert property (e_cfg[9:8] == 2'b11 && e_cfg[11:10] != 2'b11
    |-> periph_sense.timer_ext_clock_in == pin_in_e[4])
    else $error("timer clock not routed");

  c_mode_write: cover property (e_wr);
  c_slave_error: cover property (acc && pslverr);
  c_uart_mode: cover property (e_cfg[5:4] == 2'b10);
endmodule

bind gefg_top gefg_chk #(.ADDR_W(ADDR_W)) i_gefg_chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .pin_in_e(pin_in_e), .pin_out_e(pin_out_e), .pin_oe_e(pin_oe_e), .pullup_en_e(pullup_en_e),
  .pullup_en_f(pullup_en_f), .periph_drive(periph_drive), .periph_sense(periph_sense),
  .byte_order_select(byte_order_select));

// file: test_gefg_top.sv
// self-checking bench for the e/f/g pin logic
`timescale 1ns/1ps
module test_gefg_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic pready, pslverr, bsel, err;
  logic [31:0] prdata, rd, lvl;
  logic [8:0] in_e, out_e, oe_e, in_f, out_f, oe_f, pu_f;
  logic [7:0] pu_e, in_g, out_g, oe_g, pu_g;
  logic [25:0] bdrv = '0;
  logic [25:0] ben = '1;
  gefg_pkg::gefg_periph_drive_s pdrv = '0;
  gefg_pkg::gefg_periph_sense_s psen;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] mr [3][3] = '{default: '0};
  localparam logic [31:0] MSK [3][3] = '{'{32'h3FFFF, 32'h3FFFFF, 32'hFFFF}, '{32'h1FF, 32'h1FF, 32'hFF},
    '{32'hFF, 32'h1FF, 32'hFF}};

  always #4 clk = ~clk;
  // peripherals offer new values every cycle
  always @(posedge clk) pdrv <= 22'($urandom);

  gefg_top i_gefg_top (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_in_e(in_e), .pin_out_e(out_e), .pin_oe_e(oe_e), .pullup_en_e(pu_e), .pin_in_f(in_f),
    .pin_out_f(out_f), .pin_oe_f(oe_f), .pullup_en_f(pu_f), .pin_in_g(in_g), .pin_out_g(out_g),
    .pin_oe_g(oe_g), .pullup_en_g(pu_g), .periph_drive(pdrv), .periph_sense(psen), .byte_order_select(bsel));
  gefg_board #(.N(9)) i_gefg_board_e (.clk(clk), .oe(oe_e), .out(out_e), .pull({1'b0, pu_e}),
    .drv(bdrv[8:0]), .drv_en(ben[8:0]), .lvl(in_e));
  gefg_board #(.N(9)) i_gefg_board_f (.clk(clk), .oe(oe_f), .out(out_f), .pull(pu_f),
    .drv(bdrv[17:9]), .drv_en(ben[17:9]), .lvl(in_f));
  gefg_board #(.N(8)) i_gefg_board_g (.clk(clk), .oe(oe_g), .out(out_g), .pull(pu_g),
    .drv(bdrv[25:18]), .drv_en(ben[25:18]), .lvl(in_g));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer, held until ready
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // group k, register r: 0 mode, 1 data, 2 pull-up disable
  task automatic wr_reg(input int k, input int r, input logic [31:0] v);
    apb(1'b1, gefg_pkg::E_CONFIG_ADDR + 12 * k + 4 * r, v);
    mr[k][r] = v & MSK[r][k];
  endtask

  task automatic rd_reg(input int k, input int r, input logic [31:0] exp);
    apb(1'b0, gefg_pkg::E_CONFIG_ADDR + 12 * k + 4 * r, 32'h0);
    chk("register", exp, rd);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    void'($urandom(87402));
    bdrv = 26'($urandom);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    chk("pullups", 32'h1FFFFFF, 32'({pu_g, pu_f, pu_e}));
    chk("enables", 32'h0, 32'({oe_g, oe_f, oe_e}));
    chk("byte order", 32'(bdrv[8]), 32'(bsel));
    @(posedge clk);
    // reset values, then masked random read-back
    for (int k = 0; k < 3; k++)
      for (int r = 0; r < 3; r += 2)
      begin
        rd_reg(k, r, 32'h0);
        wr_reg(k, r, $urandom);
        rd_reg(k, r, mr[k][r]);
      end
    #1;
    chk("pullup enables", 32'({~mr[2][2][7:0], ~mr[1][2][8:0], ~mr[0][2][7:0]}), 32'({pu_g, pu_f, pu_e}));
    @(posedge clk);
    // unmapped word after the last register
    apb(1'b1, gefg_pkg::G_PULLUP_ADDR + 4, $urandom);
    chk("unmapped error", 32'h1, 32'(err));
    apb(1'b0, gefg_pkg::G_PULLUP_ADDR + 4, 32'h0);
    chk("unmapped data", 32'h0, rd);
    // e0 clock out, e2 uart receive, e4 timer clock, e8 reserved
    wr_reg(0, 0, 32'h30323);
    #1;
    chk("e8 enable", 32'h0, 32'(oe_e[8]));
    chk("e0 clock", 32'(pdrv.clock_out), 32'(out_e[0]));
    chk("e2 receive", 32'(in_e[2]), 32'(psen.uart0_receive));
    chk("e4 timer", 32'(in_e[4]), 32'(psen.timer_ext_clock_in));
    @(posedge clk);
    // all pins output with random data
    wr_reg(0, 0, 32'h15555);
    wr_reg(1, 0, 32'h92555);
    wr_reg(2, 0, 32'h5555);
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(k, 1, $urandom);
      rd_reg(k, 1, mr[k][1]);
    end
    #1;
    chk("enables", 32'h3FFFFFF, 32'({oe_g, oe_f, oe_e}));
    chk("pin values", 32'({mr[2][1][7:0], mr[1][1][8:0], mr[0][1][8:0]}), 32'({out_g, out_f, out_e}));
    @(posedge clk);
    // all pins input, the board drives random levels
    bdrv <= 26'($urandom);
    for (int k = 0; k < 3; k++)
      wr_reg(k, 0, 32'h0);
    for (int k = 0; k < 3; k++)
      rd_reg(k, 1, (32'(bdrv) >> (9 * k)) & MSK[1][k]);
    // board lets go: pins with the pull-up on float high
    ben <= '0;
    apb(1'b0, gefg_pkg::F_DATA_ADDR, 32'h0);
    chk("pulled pins", ~mr[1][2] & 32'h1FF, rd & ~mr[1][2]);
    // group g in interrupt mode for wake-up
    wr_reg(2, 0, 32'hFFFF);
    #1;
    chk("interrupt inputs", 32'(in_g), 32'(psen.ext_interrupt_in));
    @(posedge clk);
    // every code of the f8 three-bit field
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(1, 0, 32'(c << 19));
      #1;
      lvl = c == 1 ? 1 : c == 3 ? pdrv.sync_serial_clock_oe : c == 4 ? pdrv.audio_bit_clock_oe : 0;
      chk("f8 enable", lvl, 32'(oe_f[8]));
      if (c == 2)
        chk("f8 clear to send", 32'(in_f[8]), 32'(psen.uart1_clear_to_send_n));
      @(posedge clk);
    end
    // second reset in mid-run
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd_reg(1, 0, 32'h0);
    test_done;
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done;
  end
endmodule
